//--- hdl/rtcsat_params.svh
// Overview of operation
// - Power-up loads calendar 00-01-01 day 0 00:00:00 and the listed register values.
// - Power-up sets the power-applied flag; software initialization clears it.
// - Initialization reloads calendar, keeps status one bits 6..4, zeroes others.
// - Supply is sampled once per second during a 15.6 ms window only.
// - A low sample sets the sticky low-supply flag and stops sampling.
// - Reading or initialization clears the low-supply flag and resumes sampling.
// - Written year with a nibble above nine becomes 00.
// - Invalid written month or day becomes 01.
// - Written weekday 7 becomes 0; invalid hour for the mode becomes 00.
// - Bad seconds are fixed on the next second carry, which advances minutes.
// - 24-hour mode ignores written afternoon bit; reads show hour 12..23.
// - A day past month end becomes the first of the following month.
// - Matching weekday, hour, minute on enabled fields sets the alarm flag.
// - Trim adjusts divider counts every 20 s, or 60 s with trim bit 0 set.
// - Trim steps are 3.052 ppm or 1.017 ppm, two crystal counts each.
// - Power and alarm flags are read-only and clear after a read.
// - Writing the initialization bit triggers init; it always reads zero.
`ifndef RTCSAT_PARAMS_SVH
`define RTCSAT_PARAMS_SVH
// Register indices
`define RTCSAT_A_STAT1 5'h00
`define RTCSAT_A_STAT2 5'h01
`define RTCSAT_A_CAL0 5'h02
`define RTCSAT_A_CAL6 5'h08
`define RTCSAT_A_ALM0 5'h09
`define RTCSAT_A_ALM5 5'h0E
`define RTCSAT_A_TRIM 5'h0F
`define RTCSAT_A_USER 5'h10
// Calendar slots: 0 year, 1 month, 2 day, 3 weekday, 4 hour, 5 minute, 6 second
`define RTCSAT_C_YEAR 3'h0
`define RTCSAT_C_MON 3'h1
`define RTCSAT_C_DAY 3'h2
`define RTCSAT_C_WDAY 3'h3
`define RTCSAT_C_HOUR 3'h4
`define RTCSAT_C_MIN 3'h5
`define RTCSAT_C_SEC 3'h6
// Field positions
`define RTCSAT_S1_INIT 7
`define RTCSAT_S1_24H 6
`define RTCSAT_S2_A2SEL 1
`define RTCSAT_S2_A1SEL 5
`define RTCSAT_S2_A1MIN 6
`define RTCSAT_S2_A1FRQ 7
`define RTCSAT_ALM_EN 7
`define RTCSAT_HR_PM 6
// Reset values
`define RTCSAT_RST_STAT 8'h01
`define RTCSAT_RST_ALM1 8'h80
`define RTCSAT_RST_ZERO 8'h00
`define RTCSAT_RST_ONE 8'h01
// Timing in crystal counts
`define RTCSAT_XTAL_HZ 32768
`define RTCSAT_SAMPLE_US 15600
`define RTCSAT_SAMPLE_CYC ((`RTCSAT_SAMPLE_US * `RTCSAT_XTAL_HZ) / 1000000)
`define RTCSAT_SEC_LAST (`RTCSAT_XTAL_HZ - 1)
`define RTCSAT_TRIM_SHORT_S 20
`define RTCSAT_TRIM_LONG_S 60
`define RTCSAT_TRIM_STEP 2
`endif

//--- hdl/rtcsat_pkg.sv
package rtcsat_pkg;
    typedef logic [7:0] rtcsat_byte_t;
    typedef logic [15:0] rtcsat_div_t;
endpackage

//--- hdl/rtcsat_core.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rtcsat_params.svh"
module rtcsat_core import rtcsat_pkg::*; (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [4:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Crystal clock and supply comparator
    input wire logic xtal_clk_in,
    input wire logic supply_low_in,
    // Status
    output logic second_tick_out,
    output logic alarm_one_flag_out,
    output logic alarm_two_flag_out
);
    // Calendar, alarm and control state
    rtcsat_byte_t cal_q [0:6];
    rtcsat_byte_t cal_d [0:6];
    rtcsat_byte_t alm_q [0:5];
    rtcsat_byte_t alm_d [0:5];
    rtcsat_byte_t stat2_q, stat2_d, trim_q, trim_d, user_q, user_d, rd_q, rd_d;
    rtcsat_div_t div_q, div_d, term;
    logic [5:0] ivl_q, ivl_d;
    logic [1:0] s1_user_q, s1_user_d;
    logic mode24_q, mode24_d, power_applied_flag_q, power_applied_flag_d;
    logic low_supply_flag_q, low_supply_flag_d;
    logic alarm_one_flag_q, alarm_one_flag_d, alarm_two_flag_q, alarm_two_flag_d;
    logic min_evt_q, min_evt_d, tick_q, tick_d;
    logic xs1_q, xs2_q, xs3_q, ls1_q, ls2_q;
    logic xedge, tick, c_min, c_hr, c_day, c_mon, c_yr, sample_set, alm1_hit, alm2_hit;
    logic wr_s1, rd_s1, init;
    logic [6:0] tval;
    logic [7:0] dim, hr_rd;

    // BCD increment of one byte
    function automatic rtcsat_byte_t f_inc(input rtcsat_byte_t v);
        f_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Low nibble above nine
    function automatic logic f_nib(input rtcsat_byte_t v);
        f_nib = (v[3:0] > 4'h9);
    endfunction

    // Last day of a month, BCD; leap test works on BCD year digits
    function automatic rtcsat_byte_t f_dim(input rtcsat_byte_t m, input rtcsat_byte_t y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: f_dim = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: f_dim = 8'h30;
            default: f_dim = 8'h31;
        endcase
    endfunction

    // Alarm comparison over enabled fields; a bank with no field enabled never fires
    function automatic logic f_alm(input rtcsat_byte_t w, input rtcsat_byte_t h,
                                   input rtcsat_byte_t m, input rtcsat_byte_t cw,
                                   input rtcsat_byte_t ch, input rtcsat_byte_t cm,
                                   input logic m24);
        logic hok;
        hok = m24 ? (h[5:0] == ch[5:0]) : (h[6:0] == ch[6:0]);
        f_alm = (w[`RTCSAT_ALM_EN] | h[`RTCSAT_ALM_EN] | m[`RTCSAT_ALM_EN])
              & (~w[`RTCSAT_ALM_EN] | (w[2:0] == cw[2:0]))
              & (~h[`RTCSAT_ALM_EN] | hok)
              & (~m[`RTCSAT_ALM_EN] | (m[6:0] == cm[6:0]));
    endfunction

    // Two-stage synchronisers; xs3 only serves the edge detector
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
            ls1_q <= 1'b0;
            ls2_q <= 1'b0;
        end else begin
            xs1_q <= xtal_clk_in;
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
            ls1_q <= supply_low_in;
            ls2_q <= ls1_q;
        end
    end

    // Strobe decode and crystal edge
    assign xedge = xs2_q & ~xs3_q;
    assign wr_s1 = reg_wr_in && reg_addr_in == `RTCSAT_A_STAT1;
    assign rd_s1 = reg_rd_in && reg_addr_in == `RTCSAT_A_STAT1;
    assign init = wr_s1 && reg_wdata_in[`RTCSAT_S1_INIT];
    // Trim value sits bit-reversed in bits 7..1
    assign tval = {trim_q[1], trim_q[2], trim_q[3], trim_q[4], trim_q[5], trim_q[6], trim_q[7]};
    assign dim = f_dim(cal_q[`RTCSAT_C_MON], cal_q[`RTCSAT_C_YEAR]);
    // 24-hour reads derive the afternoon bit from the count
    assign hr_rd = mode24_q ? {1'b0, (cal_q[`RTCSAT_C_HOUR][5:0] > 6'h11),
                               cal_q[`RTCSAT_C_HOUR][5:0]} : cal_q[`RTCSAT_C_HOUR];
    assign alm1_hit = stat2_q[`RTCSAT_S2_A1SEL] & ~stat2_q[`RTCSAT_S2_A1MIN]
                    & ~stat2_q[`RTCSAT_S2_A1FRQ]
                    & f_alm(alm_q[0], alm_q[1], alm_q[2], cal_q[`RTCSAT_C_WDAY],
                            cal_q[`RTCSAT_C_HOUR], cal_q[`RTCSAT_C_MIN], mode24_q);
    assign alarm_one_flag_out = alarm_one_flag_q;
    assign alarm_two_flag_out = alarm_two_flag_q;
    assign second_tick_out = tick_q;
    assign reg_rdata_out = rd_q;
    assign alm2_hit = stat2_q[`RTCSAT_S2_A2SEL]
                    & f_alm(alm_q[3], alm_q[4], alm_q[5], cal_q[`RTCSAT_C_WDAY],
                            cal_q[`RTCSAT_C_HOUR], cal_q[`RTCSAT_C_MIN], mode24_q);

    // Divider end: lengthen for a fast crystal, shorten for a slow one
    always_comb begin
        term = 16'(`RTCSAT_SEC_LAST);
        if (ivl_q == 6'h00 && tval != 7'h00) begin
            if (tval[6])
                term = term + 16'(`RTCSAT_TRIM_STEP * (8'h80 - {1'b0, tval}));
            else
                term = term - 16'(`RTCSAT_TRIM_STEP * tval);
        end
    end

    // Next-state logic for all software-visible state
    always_comb begin
        cal_d = cal_q;
        alm_d = alm_q;
        stat2_d = stat2_q;
        trim_d = trim_q;
        user_d = user_q;
        mode24_d = mode24_q;
        s1_user_d = s1_user_q;
        div_d = div_q;
        ivl_d = ivl_q;
        tick = 1'b0;
        c_min = 1'b0;
        c_hr = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        c_yr = 1'b0;
        power_applied_flag_d = power_applied_flag_q & ~rd_s1;
        low_supply_flag_d = low_supply_flag_q & ~rd_s1;
        alarm_one_flag_d = alarm_one_flag_q & ~rd_s1;
        alarm_two_flag_d = alarm_two_flag_q & ~rd_s1;
        // Sampling only inside the window and only while the flag is clear
        sample_set = xedge && div_q < 16'(`RTCSAT_SAMPLE_CYC) && !low_supply_flag_q
                     && ls2_q;
        // Crystal divider and trim interval
        if (xedge) begin
            if (div_q >= term) begin
                div_d = 16'h0000;
                tick = 1'b1;
                ivl_d = (ivl_q >= (trim_q[0] ? 6'(`RTCSAT_TRIM_LONG_S - 1)
                                             : 6'(`RTCSAT_TRIM_SHORT_S - 1))) ? 6'h00
                                                                                : ivl_q + 6'h01;
            end else begin
                div_d = div_q + 16'h0001;
            end
        end
        // Carry chain; a bad seconds value is fixed here and still carries
        if (tick) begin
            if (cal_q[6] >= 8'h59 || f_nib(cal_q[6])) begin
                cal_d[6] = 8'h00;
                c_min = 1'b1;
            end else begin
                cal_d[6] = f_inc(cal_q[6]);
            end
        end
        if (c_min) begin
            c_hr = cal_q[5] == 8'h59;
            cal_d[5] = c_hr ? 8'h00 : f_inc(cal_q[5]);
        end
        if (c_hr) begin
            if (mode24_q) begin
                c_day = cal_q[4][5:0] == 6'h23;
                cal_d[4] = c_day ? 8'h00 : f_inc(cal_q[4]);
            end else if (cal_q[4][5:0] == 6'h11) begin
                c_day = cal_q[4][`RTCSAT_HR_PM];
                cal_d[4] = {1'b0, ~cal_q[4][`RTCSAT_HR_PM], 6'h00};
            end else begin
                cal_d[4] = f_inc(cal_q[4]);
            end
        end
        if (c_day) begin
            cal_d[3] = (cal_q[3] == 8'h06) ? 8'h00 : cal_q[3] + 8'h01;
            c_mon = cal_q[2] >= dim;
            cal_d[2] = c_mon ? 8'h01 : f_inc(cal_q[2]);
        end
        if (c_mon) begin
            c_yr = cal_q[1] == 8'h12;
            cal_d[1] = c_yr ? 8'h01 : f_inc(cal_q[1]);
        end
        if (c_yr)
            cal_d[0] = (cal_q[0] == 8'h99) ? 8'h00 : f_inc(cal_q[0]);
        // Register writes with validation
        if (reg_wr_in) begin
            case (reg_addr_in)
                `RTCSAT_A_STAT1: begin
                    mode24_d = reg_wdata_in[`RTCSAT_S1_24H];
                    s1_user_d = reg_wdata_in[5:4];
                end
                `RTCSAT_A_STAT2: stat2_d = reg_wdata_in;
                `RTCSAT_A_TRIM: trim_d = reg_wdata_in;
                `RTCSAT_A_USER: user_d = reg_wdata_in;
                5'h02: cal_d[0] = (f_nib(reg_wdata_in) || reg_wdata_in[7:4] > 4'h9) ? 8'h00
                                                                              : reg_wdata_in;
                5'h03: cal_d[1] = (reg_wdata_in == 8'h00 || reg_wdata_in > 8'h12
                                   || f_nib(reg_wdata_in)) ? 8'h01 : reg_wdata_in;
                5'h04: cal_d[2] = (reg_wdata_in == 8'h00 || reg_wdata_in > 8'h31
                                   || f_nib(reg_wdata_in)) ? 8'h01 : reg_wdata_in;
                5'h05: cal_d[3] = {5'h00, (reg_wdata_in[2:0] == 3'h7) ? 3'h0
                                                                      : reg_wdata_in[2:0]};
                5'h06: begin
                    if (mode24_q)
                        cal_d[4] = (reg_wdata_in[5:0] > 6'h23 || f_nib(reg_wdata_in)) ? 8'h00
                                   : {2'b00, reg_wdata_in[5:0]};
                    else
                        cal_d[4] = (reg_wdata_in[5:0] > 6'h11 || f_nib(reg_wdata_in)) ? 8'h00
                                   : {1'b0, reg_wdata_in[6:0]};
                end
                5'h07: cal_d[5] = (reg_wdata_in[6:0] > 7'h59 || f_nib(reg_wdata_in)) ? 8'h00
                                  : {1'b0, reg_wdata_in[6:0]};
                5'h08: cal_d[6] = {1'b0, reg_wdata_in[6:0]};
                default: begin
                    if (reg_addr_in >= `RTCSAT_A_ALM0 && reg_addr_in <= `RTCSAT_A_ALM5)
                        alm_d[3'(reg_addr_in - `RTCSAT_A_ALM0)] = reg_wdata_in;
                end
            endcase
            // Day beyond month end rolls to the first of the next month
            if ((reg_addr_in == 5'h03 || reg_addr_in == 5'h04)
                && cal_d[2] > f_dim(cal_d[1], cal_d[0])) begin
                cal_d[2] = 8'h01;
                cal_d[1] = (cal_d[1] == 8'h12) ? 8'h01 : f_inc(cal_d[1]);
            end
        end
        // Alarm compare runs once the new minute has settled; set wins over read
        if (min_evt_q && alm1_hit)
            alarm_one_flag_d = 1'b1;
        if (min_evt_q && alm2_hit)
            alarm_two_flag_d = 1'b1;
        if (sample_set)
            low_supply_flag_d = 1'b1;
        // Initialization overrides everything except status one bits 6..4
        if (init) begin
            for (int i = 0; i < 7; i++)
                cal_d[i] = 8'h00;
            cal_d[1] = `RTCSAT_RST_ONE;
            cal_d[2] = `RTCSAT_RST_ONE;
            for (int i = 0; i < 6; i++)
                alm_d[i] = `RTCSAT_RST_ZERO;
            stat2_d = `RTCSAT_RST_ZERO;
            trim_d = `RTCSAT_RST_ZERO;
            user_d = `RTCSAT_RST_ZERO;
            power_applied_flag_d = 1'b0;
            low_supply_flag_d = 1'b0;
            alarm_one_flag_d = 1'b0;
            alarm_two_flag_d = 1'b0;
        end
        min_evt_d = c_min;
        tick_d = tick;
    end

    // Read data; status one shows flags before the read clears them
    always_comb begin
        rd_d = rd_q;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `RTCSAT_A_STAT1: rd_d = {1'b0, mode24_q, s1_user_q, alarm_one_flag_q,
                                         alarm_two_flag_q, low_supply_flag_q,
                                         power_applied_flag_q};
                `RTCSAT_A_STAT2: rd_d = stat2_q;
                `RTCSAT_A_TRIM: rd_d = trim_q;
                `RTCSAT_A_USER: rd_d = user_q;
                5'h06: rd_d = hr_rd;
                default: begin
                    if (reg_addr_in >= `RTCSAT_A_CAL0 && reg_addr_in <= `RTCSAT_A_CAL6)
                        rd_d = cal_q[3'(reg_addr_in - `RTCSAT_A_CAL0)];
                    else if (reg_addr_in >= `RTCSAT_A_ALM0 && reg_addr_in <= `RTCSAT_A_ALM5)
                        rd_d = alm_q[3'(reg_addr_in - `RTCSAT_A_ALM0)];
                    else
                        rd_d = 8'h00;
                end
            endcase
        end
    end

    // State registers; power-up values
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cal_q <= '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
            alm_q <= '{`RTCSAT_RST_ALM1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
            stat2_q <= `RTCSAT_RST_STAT;
            trim_q <= `RTCSAT_RST_ZERO;
            user_q <= `RTCSAT_RST_ZERO;
            rd_q <= 8'h00;
            div_q <= 16'h0000;
            ivl_q <= 6'h00;
            s1_user_q <= 2'b00;
            mode24_q <= 1'b0;
            power_applied_flag_q <= 1'b1;
            low_supply_flag_q <= 1'b0;
            alarm_one_flag_q <= 1'b0;
            alarm_two_flag_q <= 1'b0;
            min_evt_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            cal_q <= cal_d;
            alm_q <= alm_d;
            stat2_q <= stat2_d;
            trim_q <= trim_d;
            user_q <= user_d;
            rd_q <= rd_d;
            div_q <= div_d;
            ivl_q <= ivl_d;
            s1_user_q <= s1_user_d;
            mode24_q <= mode24_d;
            power_applied_flag_q <= power_applied_flag_d;
            low_supply_flag_q <= low_supply_flag_d;
            alarm_one_flag_q <= alarm_one_flag_d;
            alarm_two_flag_q <= alarm_two_flag_d;
            min_evt_q <= min_evt_d;
            tick_q <= tick_d;
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_wr_bad_year;
        reg_wr_in && reg_addr_in == 5'h02 && reg_wdata_in[7:4] > 4'h9;
    endsequence
    sequence s_low_hold;
        low_supply_flag_q && !rd_s1 && !init;
    endsequence

    property p_power_vals;
        $past(sys_rst_in) |-> power_applied_flag_q && stat2_q == 8'h01 && alm_q[0] == 8'h80;
    endproperty
    a_power_vals: assert property (p_power_vals) else $error("bad power-up values");
    property p_init;
        init |=> !power_applied_flag_q && trim_q == 8'h00 && cal_q[2] == 8'h01
                 && mode24_q == $past(reg_wdata_in[`RTCSAT_S1_24H]);
    endproperty
    a_init: assert property (p_init) else $error("init did not reload");
    property p_window;
        sample_set |-> div_q < 16'd511 && !low_supply_flag_q;
    endproperty
    a_window: assert property (p_window) else $error("sample outside window");
    property p_low_sticky;
        s_low_hold |=> low_supply_flag_q;
    endproperty
    a_low_sticky: assert property (p_low_sticky) else $error("low flag lost");
    property p_low_clear;
        rd_s1 && !sample_set |=> !low_supply_flag_q;
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("low flag not cleared");
    property p_year_fix;
        (s_wr_bad_year and !init) ##1 !$past(tick) |-> cal_q[0] == 8'h00;
    endproperty
    a_year_fix: assert property (p_year_fix) else $error("bad year kept");
    property p_wday_fix;
        reg_wr_in && reg_addr_in == 5'h05 && reg_wdata_in[2:0] == 3'h7 && !init
            |=> cal_q[3] == 8'h00;
    endproperty
    a_wday_fix: assert property (p_wday_fix) else $error("weekday 7 kept");
    property p_alarm;
        min_evt_q && alm1_hit && !init |=> alarm_one_flag_q ##1 1'b1;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm one missed");
    property p_init_bit;
        rd_s1 |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[0] == $past(power_applied_flag_q);
    endproperty
    a_init_bit: assert property (p_init_bit) else $error("status one read wrong");
endmodule
`default_nettype wire

//--- tb/rtcsat_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host processor that reaches the clock core over the register port
module rtcsat_host_model (
    // Clock
    input wire logic mclk_in,
    // Register port towards the core
    output logic [4:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out
);
    // Bus idles with both strobes low
    initial begin
        reg_addr_out = 5'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end

    // One access per call; the gap cycle keeps every edge to a single assignment
    task automatic access(input logic [4:0] a, input logic [7:0] d, input logic w);
        @(posedge mclk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= w;
        reg_rd_out <= !w;
        @(posedge mclk_in);
        reg_wr_out <= 1'b0;
        reg_rd_out <= 1'b0;
        reg_wdata_out <= ~d; // Released data must not keep its last value
    endtask

    // Power-up settling before the first transfer, scaled down for simulation
    task automatic settle(input int cycles);
        repeat (cycles) @(posedge mclk_in);
    endtask

    // Trim code: fast clock 128 minus ratio, slow clock ratio plus one, bits reversed
    function automatic logic [7:0] trim_code(input int ratio, input logic fast, input logic lng);
        logic [6:0] v;
        logic [6:0] r;
        v = fast ? 7'(128 - ratio) : 7'(ratio + 1);
        r = {<<{v}};
        return {r, lng};
    endfunction
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtcsat_params.svh"
module testbench;
    import rtcsat_pkg::*;
    logic mclk_in;
    logic sys_rst_in;
    logic xtal_clk_in;
    logic supply_low_in;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr_s;
    logic rd_s;
    logic rd_d;
    logic [7:0] rdata;
    logic tick;
    logic al1;
    logic al2;
    rtcsat_byte_t exp_q[$];
    rtcsat_byte_t v;
    int failures;
    int compares;
    integer seed;
    // Calendar write, expected readback: {index, written, expected}
    logic [20:0] tab[23] = '{{5'h02, 8'h3A, 8'h00}, {5'h02, 8'hA5, 8'h00}, {5'h02, 8'h99, 8'h99},
        {5'h03, 8'h00, 8'h01}, {5'h03, 8'h13, 8'h01}, {5'h03, 8'h1A, 8'h01}, {5'h03, 8'h12, 8'h12},
        {5'h04, 8'h00, 8'h01}, {5'h04, 8'h32, 8'h01}, {5'h04, 8'h1F, 8'h01}, {5'h04, 8'h31, 8'h31},
        {5'h05, 8'h07, 8'h00}, {5'h05, 8'h06, 8'h06}, {5'h06, 8'h12, 8'h00}, {5'h06, 8'h20, 8'h00},
        {5'h06, 8'h0A, 8'h00}, {5'h06, 8'h51, 8'h51}, {5'h07, 8'h60, 8'h00}, {5'h07, 8'h5A, 8'h00},
        {5'h07, 8'h59, 8'h59}, {5'h06, 8'h25, 8'h00}, {5'h05, 8'h03, 8'h03},
        {5'h08, 8'hC5, 8'h45}};

    rtcsat_core DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .xtal_clk_in(xtal_clk_in), .supply_low_in(supply_low_in), .second_tick_out(tick),
        .alarm_one_flag_out(al1), .alarm_two_flag_out(al2));
    rtcsat_host_model host (.mclk_in(mclk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
        .reg_wr_out(wr_s), .reg_rd_out(rd_s));

    // Clocks; the crystal keeps a fixed phase offset from the system clock
    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end
    initial begin
        xtal_clk_in = 1'b0;
        #7.3;
        forever #80 xtal_clk_in = ~xtal_clk_in;
    end

    task automatic check(input rtcsat_byte_t got, input rtcsat_byte_t exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input rtcsat_byte_t d);
        host.access(a, d, 1'b1);
    endtask
    task automatic rd(input logic [4:0] a, input rtcsat_byte_t e);
        exp_q.push_back(e);
        host.access(a, 8'h00, 1'b0);
    endtask
    // Every register from year to user byte against its reset value
    task automatic rd_defaults(input rtcsat_byte_t alm_one);
        for (int a = 2; a <= 16; a++) begin
            rd(5'(a), (a == 3 || a == 4) ? 8'h01 : (a == 9) ? alm_one : 8'h00);
        end
    endtask
    // Keep supply low for a number of crystal edges
    task automatic supply_dip(input int edges);
        @(posedge mclk_in);
        supply_low_in <= 1'b1;
        repeat (edges) @(posedge xtal_clk_in);
        @(posedge mclk_in);
        supply_low_in <= 1'b0;
        repeat (8) @(posedge xtal_clk_in);
    endtask
    task automatic complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Read data appear in the cycle after the strobe and hold until the next read; look mid-cycle
    always @(posedge mclk_in) rd_d <= rd_s;
    always @(negedge mclk_in) begin
        if (rd_d === 1'b1)
            check(rdata, exp_q.pop_front());
        // No second elapses in this run, so neither tick nor alarm may appear
        if (sys_rst_in === 1'b0)
            check({5'h00, tick, al1, al2}, 8'h00);
    end

    initial begin
        #400000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        sys_rst_in = 1'b1;
        supply_low_in = 1'b0;
        failures = 0;
        compares = 0;
        seed = 32'h85d823a1;
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        host.settle(4);
        rd(`RTCSAT_A_STAT1, 8'h01);
        rd(`RTCSAT_A_STAT1, 8'h00);
        rd(`RTCSAT_A_STAT2, 8'h01);
        rd_defaults(8'h80);
        wr(5'h1F, 8'hFF);
        rd(5'h1F, 8'h00);
        // Low supply inside the first sampling window, sticky after recovery
        supply_dip(20);
        rd(`RTCSAT_A_STAT1, 8'h02);
        rd(`RTCSAT_A_STAT1, 8'h00);
        // Past the window no sample is taken
        repeat (800) @(posedge xtal_clk_in);
        supply_dip(20);
        rd(`RTCSAT_A_STAT1, 8'h00);
        foreach (tab[i]) begin
            wr(tab[i][20:16], tab[i][15:8]);
            rd(tab[i][20:16], tab[i][7:0]);
        end
        wr(`RTCSAT_A_STAT1, 8'h40);
        wr(5'h06, 8'h15);
        rd(5'h06, 8'h55);
        wr(5'h06, 8'h48);
        rd(5'h06, 8'h08);
        wr(5'h06, 8'h24);
        rd(5'h06, 8'h00);
        wr(5'h04, 8'h01);
        wr(5'h03, 8'h02);
        wr(5'h04, 8'h30);
        rd(5'h03, 8'h03);
        rd(5'h04, 8'h01);
        wr(`RTCSAT_A_TRIM, host.trim_code(29, 1'b1, 1'b0));
        rd(`RTCSAT_A_TRIM, 8'hC6);
        wr(`RTCSAT_A_TRIM, host.trim_code(30, 1'b0, 1'b0));
        rd(`RTCSAT_A_TRIM, 8'hF8);
        wr(`RTCSAT_A_TRIM, 8'h00);
        repeat (4) begin
            v = 8'($random(seed));
            wr(`RTCSAT_A_USER, v);
            rd(`RTCSAT_A_USER, v);
        end
        // Initialization keeps mode and user bits, sets month and day to 01, zeroes everything else
        wr(`RTCSAT_A_STAT2, 8'h1C);
        wr(`RTCSAT_A_ALM0, 8'h85);
        wr(`RTCSAT_A_ALM5, 8'h97);
        wr(`RTCSAT_A_TRIM, 8'h3B);
        wr(`RTCSAT_A_USER, 8'hA5);
        rd(`RTCSAT_A_ALM0, 8'h85);
        rd(`RTCSAT_A_ALM5, 8'h97);
        rd(`RTCSAT_A_TRIM, 8'h3B);
        wr(`RTCSAT_A_STAT1, 8'h70);
        wr(`RTCSAT_A_STAT1, 8'hF0);
        rd(`RTCSAT_A_STAT1, 8'h70);
        rd(`RTCSAT_A_STAT2, 8'h00);
        rd_defaults(8'h00);
        repeat (4) @(posedge mclk_in);
        complete_run();
    end
endmodule
`default_nettype wire
